// ==== hw/lavr_regs.v ====
// Alternate (B) voltage register bank for regulators five and six, APB slave.
// Assumes an APB master on sys_clk; b_select inputs come from logic on the same clock.
//
// How it works
// - Sleep bit 0 with B setting selected: regulator runs normal mode.
// - Sleep bit 1 with B setting selected: regulator runs sleep mode.
// - Codes 000000 to 000010 all decode to 0.90 V.
// - From 000011 the target rises 50 mV per code, 0.95 V first.
// - Code 001000 decodes to 1.20 V.
// - Code 110000 decodes to 3.20 V.
// - Code 111000 and above all decode to 3.60 V.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`include "lavr_defines.vh"
`default_nettype none
module lavr_regs #(
	parameter [7:0] REG_FIVE_RESET = `LAVR_RESET_VAL,
	parameter [7:0] REG_SIX_RESET = `LAVR_RESET_VAL
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`LAVR_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Setting selection from the A/B chooser
	input wire reg_five_b_select,
	input wire reg_six_b_select,
	// Regulator five controls
	output wire reg_five_alt_sleep_select,
	output wire [`LAVR_CODE_W-1:0] reg_five_alt_voltage_code,
	output wire [`LAVR_MV_W-1:0] reg_five_alt_target_mv,
	output wire [1:0] reg_five_mode,
	output wire reg_five_alt_update,
	// Regulator six controls
	output wire reg_six_alt_sleep_select,
	output wire [`LAVR_CODE_W-1:0] reg_six_alt_voltage_code,
	output wire [`LAVR_MV_W-1:0] reg_six_alt_target_mv,
	output wire [1:0] reg_six_mode,
	output wire reg_six_alt_update
);
	localparam NUM_REGS = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode

	// Returns a one-hot hit vector; zero for an unmapped or misaligned address
	function [NUM_REGS-1:0] addr_hit;
		input [`LAVR_ADDR_W-1:0] addr;
		begin
			addr_hit = {NUM_REGS{1'b0}};
			if (addr == `LAVR_ADDR_REG_FIVE) begin
				addr_hit[0] = 1'b1;
			end
			if (addr == `LAVR_ADDR_REG_SIX) begin
				addr_hit[1] = 1'b1;
			end
		end
	endfunction

	// Mode a regulator is told to run in, from selection and sleep bit
	function [1:0] run_mode;
		input b_sel;
		input sleep_bit;
		begin
			if (!b_sel) begin
				run_mode = `LAVR_MODE_A;
			end else if (sleep_bit) begin
				run_mode = `LAVR_MODE_B_SLEEP;
			end else begin
				run_mode = `LAVR_MODE_B_NORMAL;
			end
		end
	endfunction

	wire [NUM_REGS-1:0] hit;
	wire access;
	wire setup;
	wire mapped;
	wire wr_lane;
	wire [NUM_REGS-1:0] wr_en;
	wire [7:0] reg_q [0:NUM_REGS-1];
	wire [`LAVR_MV_W-1:0] target_mv [0:NUM_REGS-1];
	wire [NUM_REGS-1:0] b_select;

	assign hit = addr_hit(paddr);
	assign mapped = |hit;
	assign setup = psel & ~penable;
	assign access = psel & penable;
	// Only byte lane 0 holds data; a write without it stores nothing
	assign wr_lane = pstrb[0];
	assign b_select = {reg_six_b_select, reg_five_b_select};

	////////////////////////////////////////////////////////////////////////////////
	// APB handshake

	// Zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	// Unmapped addresses answer with an error and leave every register untouched
	assign pslverr = access & ~mapped;

	////////////////////////////////////////////////////////////////////////////////
	// Register storage

	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi = gi + 1) begin : g_reg
			// Reserved bit 6 is stored as written; software keeps it zero
			assign wr_en[gi] = access & pwrite & hit[gi] & wr_lane;

			lavr_reg_byte #(
				.RESET_VAL(gi == 0 ? REG_FIVE_RESET : REG_SIX_RESET)
			) u_reg (
				.sys_clk(sys_clk),
				.rst(rst),
				.wr_en(wr_en[gi]),
				.wdata(pwdata[7:0]),
				.q(reg_q[gi])
			);

			lavr_voltage_decode u_decode (
				.sys_clk(sys_clk),
				.rst(rst),
				.code(reg_q[gi][`LAVR_CODE_MSB:`LAVR_CODE_LSB]),
				.target_mv(target_mv[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Read data

	// Read data is captured in the setup cycle so it comes from a flip-flop
	// and is stable for the whole access phase
	reg [31:0] prdata_ff;
	reg [31:0] nxt_prdata;

	always @* begin
		nxt_prdata = prdata_ff;
		if (setup) begin
			nxt_prdata = 32'h0000_0000;
			if (!pwrite && hit[0]) begin
				nxt_prdata = {24'h00_0000, reg_q[0]};
			end else if (!pwrite && hit[1]) begin
				nxt_prdata = {24'h00_0000, reg_q[1]};
			end
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			prdata_ff <= 32'h0000_0000;
		end else begin
			prdata_ff <= nxt_prdata;
		end
	end

	assign prdata = prdata_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Regulator controls

	reg [1:0] five_mode_ff;
	reg [1:0] six_mode_ff;
	reg [NUM_REGS-1:0] update_ff;
	reg [1:0] nxt_five_mode;
	reg [1:0] nxt_six_mode;
	reg [NUM_REGS-1:0] nxt_update;

	always @* begin
		nxt_five_mode = run_mode(b_select[0], reg_q[0][`LAVR_SLEEP_BIT]);
		nxt_six_mode = run_mode(b_select[1], reg_q[1][`LAVR_SLEEP_BIT]);
		// Pulse one cycle after a write, when the new code is valid; the target follows a cycle later
		nxt_update = wr_en;
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			five_mode_ff <= `LAVR_MODE_A;
			six_mode_ff <= `LAVR_MODE_A;
			update_ff <= {NUM_REGS{1'b0}};
		end else begin
			five_mode_ff <= nxt_five_mode;
			six_mode_ff <= nxt_six_mode;
			update_ff <= nxt_update;
		end
	end

	assign reg_five_alt_sleep_select = reg_q[0][`LAVR_SLEEP_BIT];
	assign reg_five_alt_voltage_code = reg_q[0][`LAVR_CODE_MSB:`LAVR_CODE_LSB];
	assign reg_five_alt_target_mv = target_mv[0];
	assign reg_five_mode = five_mode_ff;
	assign reg_five_alt_update = update_ff[0];

	assign reg_six_alt_sleep_select = reg_q[1][`LAVR_SLEEP_BIT];
	assign reg_six_alt_voltage_code = reg_q[1][`LAVR_CODE_MSB:`LAVR_CODE_LSB];
	assign reg_six_alt_target_mv = target_mv[1];
	assign reg_six_mode = six_mode_ff;
	assign reg_six_alt_update = update_ff[1];
endmodule // lavr_regs
`default_nettype wire

// ==== hw/lavr_defines.vh ====
// Constants for the alternate-voltage register bank of two linear regulators.
// Assumes byte addressing on a 32-bit APB bus, one aligned word per register.
`ifndef LAVR_DEFINES_VH
`define LAVR_DEFINES_VH

// Printed register indices; byte address is four times the index
`define LAVR_IDX_REG_FIVE 8'hbe
`define LAVR_IDX_REG_SIX 8'hbf
`define LAVR_ADDR_REG_FIVE 12'h2f8
`define LAVR_ADDR_REG_SIX 12'h2fc
`define LAVR_ADDR_W 12

// Field layout inside each register byte
`define LAVR_SLEEP_BIT 7
`define LAVR_RSVD_BIT 6
`define LAVR_CODE_MSB 5
`define LAVR_CODE_LSB 0
`define LAVR_CODE_W 6

// Reset value of each register (not documented, neutral choice)
`define LAVR_RESET_VAL 8'h00

// Voltage decode, millivolts
`define LAVR_MV_W 12
`define LAVR_MV_FLOOR 12'h384
`define LAVR_MV_CEIL 12'he10
`define LAVR_MV_STEP 12'h032
`define LAVR_CODE_FLOOR_MAX 6'h02
`define LAVR_CODE_CEIL_MIN 6'h38

// Mode encoding driven to each regulator
`define LAVR_MODE_A 2'h0
`define LAVR_MODE_B_NORMAL 2'h1
`define LAVR_MODE_B_SLEEP 2'h2

`endif

// ==== hw/lavr_reg_byte.v ====
// One 8-bit software register with byte-lane write.
// Assumes write enable is a single-cycle strobe from the bus slave.
`timescale 1ns/10ps
`default_nettype none
module lavr_reg_byte #(
	parameter [7:0] RESET_VAL = 8'h00
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Write side
	input wire wr_en,
	input wire [7:0] wdata,
	// Stored value
	output wire [7:0] q
);
	reg [7:0] q_ff;
	reg [7:0] nxt_q;

	always @* begin
		nxt_q = q_ff;
		if (wr_en) begin
			nxt_q = wdata;
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			q_ff <= RESET_VAL;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign q = q_ff;
endmodule // lavr_reg_byte
`default_nettype wire

// ==== hw/lavr_voltage_decode.v ====
// Maps a 6-bit regulator voltage code to a target in millivolts.
// Assumes the code is stable from a register; result is registered.
`timescale 1ns/10ps
`include "lavr_defines.vh"
`default_nettype none
module lavr_voltage_decode (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Code in
	input wire [`LAVR_CODE_W-1:0] code,
	// Target out, millivolts
	output wire [`LAVR_MV_W-1:0] target_mv
);
	reg [`LAVR_MV_W-1:0] target_mv_ff;
	reg [`LAVR_MV_W-1:0] nxt_target_mv;
	reg [`LAVR_MV_W-1:0] steps;

	always @* begin
		steps = {{(`LAVR_MV_W-`LAVR_CODE_W){1'b0}}, code - `LAVR_CODE_FLOOR_MAX};
		if (code <= `LAVR_CODE_FLOOR_MAX) begin
			nxt_target_mv = `LAVR_MV_FLOOR;
		end else if (code >= `LAVR_CODE_CEIL_MIN) begin
			nxt_target_mv = `LAVR_MV_CEIL;
		end else begin
			// 0.90 V plus 50 mV per code above the floor
			nxt_target_mv = `LAVR_MV_FLOOR + steps * `LAVR_MV_STEP;
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			target_mv_ff <= `LAVR_MV_FLOOR;
		end else begin
			target_mv_ff <= nxt_target_mv;
		end
	end

	assign target_mv = target_mv_ff;
endmodule // lavr_voltage_decode
`default_nettype wire

// ==== testbench/lavr_regs_assertions.sv ====
// Checker for the alternate-voltage register bank.
// Assumes it is bound to lavr_regs and sees its ports only.
`timescale 1ns/10ps
`include "lavr_defines.vh"
`default_nettype none
module lavr_checker (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Bus side
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	// Regulator side
	input wire reg_five_b_select,
	input wire reg_six_b_select,
	input wire reg_five_alt_sleep_select,
	input wire reg_six_alt_sleep_select,
	input wire [5:0] reg_five_alt_voltage_code,
	input wire [5:0] reg_six_alt_voltage_code,
	input wire [11:0] reg_five_alt_target_mv,
	input wire [11:0] reg_six_alt_target_mv,
	input wire [1:0] reg_five_mode,
	input wire [1:0] reg_six_mode
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	a_five_normal: assert property (reg_five_b_select && !reg_five_alt_sleep_select
		|=> reg_five_mode == `LAVR_MODE_B_NORMAL) else $error("mode five not normal");
	a_six_sleep: assert property (reg_six_b_select && reg_six_alt_sleep_select
		|=> reg_six_mode == `LAVR_MODE_B_SLEEP) else $error("mode six not sleep");
	a_floor_decode: assert property (reg_five_alt_voltage_code <= 6'h02
		|=> reg_five_alt_target_mv == 12'h384) else $error("floor decode wrong");
	a_step_decode: assert property (reg_five_alt_voltage_code inside {[6'h03:6'h37]}
		|=> reg_five_alt_target_mv == 12'd800 + 12'd50 * $past(reg_five_alt_voltage_code))
		else $error("step decode wrong");
	a_code_eight: assert property (reg_six_alt_voltage_code == 6'h08
		|=> reg_six_alt_target_mv == 12'h4b0) else $error("code eight wrong");
	a_code_high: assert property (reg_five_alt_voltage_code == 6'h30
		|=> reg_five_alt_target_mv == 12'hc80) else $error("code 0x30 wrong");
	a_ceil_decode: assert property (reg_six_alt_voltage_code >= 6'h38
		|=> reg_six_alt_target_mv == 12'he10) else $error("ceiling decode wrong");
	a_write_five: assert property (psel && penable && pwrite && pstrb[0] &&
		paddr == `LAVR_ADDR_REG_FIVE |=> reg_five_alt_voltage_code == $past(pwdata[5:0])
		&& reg_five_alt_sleep_select == $past(pwdata[7])) else $error("write five lost");
	c_sleep: cover property (reg_five_mode == `LAVR_MODE_B_SLEEP);
	c_ceil: cover property (reg_six_alt_target_mv == 12'he10);
	c_write: cover property (psel && penable && pwrite);
endmodule // lavr_checker
bind lavr_regs lavr_checker lavr_checker_i (
	.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.reg_five_b_select(reg_five_b_select), .reg_six_b_select(reg_six_b_select),
	.reg_five_alt_sleep_select(reg_five_alt_sleep_select),
	.reg_six_alt_sleep_select(reg_six_alt_sleep_select),
	.reg_five_alt_voltage_code(reg_five_alt_voltage_code),
	.reg_six_alt_voltage_code(reg_six_alt_voltage_code),
	.reg_five_alt_target_mv(reg_five_alt_target_mv),
	.reg_six_alt_target_mv(reg_six_alt_target_mv),
	.reg_five_mode(reg_five_mode), .reg_six_mode(reg_six_mode)
);
`default_nettype wire

// ==== testbench/lavr_regs_bench.sv ====
// Self-checking bench for the alternate-voltage register bank.
// Assumes zero-wait APB and registered decode and mode outputs.
`timescale 1ns/10ps
`include "lavr_defines.vh"
`default_nettype none
module lavr_regs_bench;
	logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic reg_five_b_select = 1'b0, reg_six_b_select = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	logic [3:0] pstrb = 4'h1;
	logic er;
	wire [31:0] prdata;
	wire pready, pslverr, reg_five_alt_sleep_select, reg_six_alt_sleep_select;
	wire reg_five_alt_update, reg_six_alt_update;
	wire [5:0] reg_five_alt_voltage_code, reg_six_alt_voltage_code;
	wire [11:0] reg_five_alt_target_mv, reg_six_alt_target_mv;
	wire [1:0] reg_five_mode, reg_six_mode;
	int fail_count = 0, total_checks = 0;
	lavr_regs lavr_regs_i (
		.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .reg_five_b_select(reg_five_b_select),
		.reg_six_b_select(reg_six_b_select),
		.reg_five_alt_sleep_select(reg_five_alt_sleep_select),
		.reg_five_alt_voltage_code(reg_five_alt_voltage_code),
		.reg_five_alt_target_mv(reg_five_alt_target_mv), .reg_five_mode(reg_five_mode),
		.reg_five_alt_update(reg_five_alt_update),
		.reg_six_alt_sleep_select(reg_six_alt_sleep_select),
		.reg_six_alt_voltage_code(reg_six_alt_voltage_code),
		.reg_six_alt_target_mv(reg_six_alt_target_mv), .reg_six_mode(reg_six_mode),
		.reg_six_alt_update(reg_six_alt_update)
	);
	always #2 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		// Watchdog ends a slave that never answers
		while (pready !== 1'b1)
			@(posedge sys_clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task stop_test;
		$display("Checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task t_reset;
		apb(1'b0, `LAVR_ADDR_REG_SIX, 32'h0);
		chk("six reset", 32'h0, rd);
		chk("five target", 32'h384, reg_five_alt_target_mv);
		apb(1'b0, 12'h300, 32'h0);
		chk("unmapped err", 32'h1, er);
		chk("unmapped data", 32'h0, rd);
		$display("t_reset done");
	endtask
	task t_decode;
		logic [5:0] c [10] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h08, 6'h30, 6'h37, 6'h38,
			6'h3f};
		logic [11:0] mv [10] = '{12'h384, 12'h384, 12'h384, 12'h3b6, 12'h3e8, 12'h4b0, 12'hc80,
			12'hdde, 12'he10, 12'he10};
		for (int i = 0; i < 10; i++) begin
			apb(1'b1, `LAVR_ADDR_REG_FIVE, {26'h0, c[i]});
			apb(1'b1, `LAVR_ADDR_REG_SIX, {26'h0, c[9-i]});
			repeat (2) @(posedge sys_clk);
			chk("five mv", mv[i], reg_five_alt_target_mv);
			chk("six mv", mv[9-i], reg_six_alt_target_mv);
			chk("five code", c[i], reg_five_alt_voltage_code);
			apb(1'b0, `LAVR_ADDR_REG_FIVE, 32'h0);
			chk("five read", {26'h0, c[i]}, rd);
		end
		$display("t_decode done");
	endtask
	task t_mode;
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, `LAVR_ADDR_REG_FIVE, {24'h0, k[1], 7'h05});
			reg_five_b_select <= k[0];
			reg_six_b_select <= k[0];
			apb(1'b1, `LAVR_ADDR_REG_SIX, {24'h0, k[1], 7'h05});
			repeat (2) @(posedge sys_clk);
			chk("five mode", k[0] ? (k[1] ? `LAVR_MODE_B_SLEEP : `LAVR_MODE_B_NORMAL) :
				`LAVR_MODE_A, reg_five_mode);
			chk("six mode", k[0] ? (k[1] ? `LAVR_MODE_B_SLEEP : `LAVR_MODE_B_NORMAL) :
				`LAVR_MODE_A, reg_six_mode);
			chk("six sleep", k[1], reg_six_alt_sleep_select);
			chk("five sleep", k[1], reg_five_alt_sleep_select);
		end
		$display("t_mode done");
	endtask
	task t_strobe;
		apb(1'b1, `LAVR_ADDR_REG_FIVE, 32'h0000_0011);
		@(posedge sys_clk);
		chk("five update", 32'h1, reg_five_alt_update);
		chk("six update", 32'h0, reg_six_alt_update);
		chk("five code", 32'h11, reg_five_alt_voltage_code);
		@(posedge sys_clk);
		chk("update pulse", 32'h0, reg_five_alt_update);
		chk("five mv 0x11", 32'h672, reg_five_alt_target_mv);
		pstrb <= 4'h0;
		apb(1'b1, `LAVR_ADDR_REG_FIVE, 32'h0000_0022);
		pstrb <= 4'h1;
		@(posedge sys_clk);
		chk("no lane", 32'h11, reg_five_alt_voltage_code);
		apb(1'b1, 12'h300, 32'h0);
		chk("unmapped wr err", 32'h1, er);
		// Second reset in mid-run must bring the decode back to its floor
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk("reset mv", 32'h384, reg_five_alt_target_mv);
		rst <= 1'b0;
		apb(1'b0, `LAVR_ADDR_REG_FIVE, 32'h0);
		chk("five cleared", 32'h0, rd);
		chk("mapped err", 32'h0, er);
		$display("t_strobe done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset;
		t_decode;
		t_mode;
		t_strobe;
		stop_test;
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		fail_count++;
		stop_test;
	end
endmodule // lavr_regs_bench
`default_nettype wire
